// >>> logic/rafm_pkg.sv
// Package with modes, register classes, and address-formation constants.
package rafm_pkg;
  // ----------------------------------------------------------------------
  // Operating modes and register classes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {MODE_REAL, MODE_PROT, MODE_V86} rafm_mode_e;
  typedef enum logic [3:0] {
    RC_GENERAL, RC_SEGMENT, RC_FLAGS, RC_CONTROL, RC_GLOBAL_BASE, RC_INTR_BASE,
    RC_LOCAL_SEL, RC_TASK_SEL, RC_FPU_DATA, RC_FPU_CTRL, RC_FPU_STAT,
    RC_FPU_IP, RC_FPU_DP, RC_DEBUG, RC_TEST
  } rafm_class_e;
  // ----------------------------------------------------------------------
  // Widths and shifts
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W     = 32;
  localparam int unsigned SEL_W      = 16;
  localparam int unsigned PL_W       = 2;
  localparam int unsigned REAL_SHIFT = 4;
  localparam logic [1:0]  PL_ZERO    = 2'h0;
  localparam logic [1:0]  SIZE_BYTE  = 2'h0;
  localparam logic [1:0]  SIZE_WORD  = 2'h1;
  localparam logic [1:0]  SIZE_DWORD = 2'h2;
  localparam logic [3:0]  LANES_BYTE = 4'h1;
  localparam logic [3:0]  LANES_WORD = 4'h3;
  localparam logic [3:0]  LANES_DW   = 4'hf;
endpackage

// >>> logic/rafm_perm_if.sv
// Interface carrying one access request and its permission verdict.
`timescale 1ns/100ps
interface rafm_perm_if;
  rafm_pkg::rafm_mode_e  mode;
  rafm_pkg::rafm_class_e rclass;
  logic                  is_store;
  logic [1:0]            cpl;
  logic [1:0]            io_privilege_level;
  logic                  allow;
  modport req (output mode, output rclass, output is_store, output cpl, output io_privilege_level,
               input allow);
  modport chk (input mode, input rclass, input is_store, input cpl, input io_privilege_level,
               output allow);
endinterface

// >>> logic/rafm_perm.sv
// Combinational register accessibility check per mode and privilege level.
`timescale 1ns/100ps
module rafm_perm (
  rafm_perm_if.chk p
);
  logic pl0;
  logic io_ok;
  logic mode_ok;
  assign pl0   = (p.cpl == rafm_pkg::PL_ZERO);
  assign io_ok = (p.cpl <= p.io_privilege_level);
  // Mode code 3 is unused; refusing every class there keeps a corrupted mode
  // from ever opening up a privileged register.
  assign mode_ok = (p.mode == rafm_pkg::MODE_REAL) || (p.mode == rafm_pkg::MODE_PROT)
                 || (p.mode == rafm_pkg::MODE_V86);

  // Decision table by mode, class and direction.
  always_comb begin
    p.allow = 1'b0;
    unique case (p.rclass)
      rafm_pkg::RC_GENERAL, rafm_pkg::RC_SEGMENT, rafm_pkg::RC_FPU_DATA,
      rafm_pkg::RC_FPU_CTRL, rafm_pkg::RC_FPU_STAT, rafm_pkg::RC_FPU_IP,
      rafm_pkg::RC_FPU_DP: begin
        p.allow = 1'b1;
      end
      rafm_pkg::RC_FLAGS: begin
        p.allow = (p.mode == rafm_pkg::MODE_V86) ? io_ok : 1'b1;
      end
      rafm_pkg::RC_CONTROL, rafm_pkg::RC_DEBUG, rafm_pkg::RC_TEST: begin
        unique case (p.mode)
          rafm_pkg::MODE_REAL: p.allow = 1'b1;
          rafm_pkg::MODE_PROT: p.allow = pl0;
          default: p.allow = (p.rclass == rafm_pkg::RC_CONTROL) && p.is_store;
        endcase
      end
      rafm_pkg::RC_GLOBAL_BASE, rafm_pkg::RC_INTR_BASE: begin
        unique case (p.mode)
          rafm_pkg::MODE_REAL: p.allow = 1'b1;
          rafm_pkg::MODE_PROT: p.allow = p.is_store | pl0;
          default: p.allow = p.is_store;
        endcase
      end
      rafm_pkg::RC_LOCAL_SEL, rafm_pkg::RC_TASK_SEL: begin
        p.allow = (p.mode == rafm_pkg::MODE_PROT) && (p.is_store | pl0);
      end
      default: p.allow = 1'b0;
    endcase
    if (!mode_ok) begin
      p.allow = 1'b0;
    end
  end
endmodule

// >>> logic/rafm_core.sv
// Top: register access check with fault, and linear/physical address formation.
// Overview of operation
// - Protected mode: control, debug, test access and table-register loads need level 0.
// - Real mode: all classes allowed except local table and task selectors.
// - V86: no control/table-base loads (stores ok); no debug/test/selector access.
// - V86: flag push and pop depend on the I/O privilege level.
// - General, segment and FPU registers are accessible in every mode and level.
// - A word puts its low byte at the lower address.
// - A doubleword puts its least significant byte at the lowest address.
// - Multi-byte operands are addressed by their least significant byte.
// - Real mode linear address is selector shifted left four plus offset.
// - Linear address is 32 bits; passes unchanged as physical when paging off.
// - Effective offset is base plus index plus displacement.
`timescale 1ns/100ps
module rafm_core (
  input  wire logic                  CLK_I,
  input  wire logic                  RSTN_I,
  input  wire logic [1:0]            MODE_I,
  input  wire logic [3:0]            CLASS_I,
  input  wire logic                  ACC_VALID_I,
  input  wire logic                  ACC_STORE_I,
  input  wire logic [1:0]            CPL_I,
  input  wire logic [1:0]            IO_PRIVILEGE_LEVEL_I,
  input  wire logic                  ADDR_VALID_I,
  input  wire logic [15:0]           SELECTOR_I,
  input  wire logic [31:0]           SEG_BASE_I,
  input  wire logic [31:0]           BASE_I,
  input  wire logic [31:0]           INDEX_I,
  input  wire logic [31:0]           DISP_I,
  input  wire logic                  PAGING_EN_I,
  input  wire logic [31:0]           STORE_DATA_I,
  input  wire logic [1:0]            SIZE_I,
  output logic                       ACC_DONE_O,
  output logic                       ACC_GRANT_O,
  output logic                       PROT_FAULT_O,
  output logic                       ADDR_VALID_O,
  output logic [31:0]                LINEAR_O,
  output logic [31:0]                PHYS_O,
  output logic                       XLATE_REQ_O,
  output logic [31:0]                MEM_DATA_O,
  output logic [3:0]                 MEM_LANES_O
);
  // ----------------------------------------------------------------------
  // Permission check
  // ----------------------------------------------------------------------
  rafm_perm_if pif ();
  assign pif.mode     = rafm_pkg::rafm_mode_e'(MODE_I);
  assign pif.rclass   = rafm_pkg::rafm_class_e'(CLASS_I);
  assign pif.is_store = ACC_STORE_I;
  assign pif.cpl      = CPL_I;
  assign pif.io_privilege_level     = IO_PRIVILEGE_LEVEL_I;

  rafm_perm u_perm (
    .p (pif.chk)
  );

  // Grant or fault one cycle after the request; a refused access never
  // produces a grant, so the register file behind it stays untouched.
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      ACC_DONE_O   <= 1'b0;
      ACC_GRANT_O  <= 1'b0;
      PROT_FAULT_O <= 1'b0;
    end else begin
      ACC_DONE_O   <= ACC_VALID_I;
      ACC_GRANT_O  <= ACC_VALID_I & pif.allow;
      PROT_FAULT_O <= ACC_VALID_I & ~pif.allow;
    end
  end

  // ----------------------------------------------------------------------
  // Address formation
  // ----------------------------------------------------------------------
  logic [31:0] offset;
  logic [31:0] seg_lin;
  logic [31:0] lin_d;
  // Sum wraps modulo 2^32, as the offset space is 32 bits wide.
  assign offset  = BASE_I + INDEX_I + DISP_I;
  assign seg_lin = (MODE_I == rafm_pkg::MODE_PROT) ? SEG_BASE_I
                 : {12'h000, SELECTOR_I, 4'h0};
  assign lin_d   = seg_lin + offset;

  // Linear address registered; physical mirrors it only with paging off.
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      ADDR_VALID_O <= 1'b0;
      LINEAR_O     <= 32'h0000_0000;
      PHYS_O       <= 32'h0000_0000;
      XLATE_REQ_O  <= 1'b0;
    end else begin
      ADDR_VALID_O <= ADDR_VALID_I;
      XLATE_REQ_O  <= ADDR_VALID_I & PAGING_EN_I;
      if (ADDR_VALID_I) begin
        LINEAR_O <= lin_d;
        PHYS_O   <= PAGING_EN_I ? 32'h0000_0000 : lin_d;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Byte order: data laid out little endian from the operand address
  // ----------------------------------------------------------------------
  logic [3:0] lanes_d;
  always_comb begin
    unique case (SIZE_I)
      rafm_pkg::SIZE_WORD:  lanes_d = rafm_pkg::LANES_WORD;
      rafm_pkg::SIZE_DWORD: lanes_d = rafm_pkg::LANES_DW;
      default:              lanes_d = rafm_pkg::LANES_BYTE;
    endcase
  end

  // Lane 0 holds the least significant byte at the operand's own address.
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      MEM_DATA_O  <= 32'h0000_0000;
      MEM_LANES_O <= 4'h0;
    end else if (ADDR_VALID_I) begin
      MEM_DATA_O  <= STORE_DATA_I;
      MEM_LANES_O <= lanes_d;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_fault_pl;
    @(posedge CLK_I) disable iff (!RSTN_I)
    (ACC_VALID_I && MODE_I == rafm_pkg::MODE_PROT && CPL_I != 2'h0
     && CLASS_I == rafm_pkg::RC_DEBUG) |=> PROT_FAULT_O && !ACC_GRANT_O;
  endproperty
  a_fault_pl: assert property (p_fault_pl) else $error("debug access granted above level 0");
  property p_real_sel;
    @(posedge CLK_I) disable iff (!RSTN_I)
    (ACC_VALID_I && MODE_I == rafm_pkg::MODE_REAL && CLASS_I == rafm_pkg::RC_TASK_SEL)
    |=> PROT_FAULT_O;
  endproperty
  a_real_sel: assert property (p_real_sel) else $error("task selector allowed in real mode");
  property p_v86_store;
    @(posedge CLK_I) disable iff (!RSTN_I)
    (ACC_VALID_I && MODE_I == rafm_pkg::MODE_V86 && CLASS_I == rafm_pkg::RC_GLOBAL_BASE)
    |=> (ACC_GRANT_O == $past(ACC_STORE_I));
  endproperty
  a_v86_store: assert property (p_v86_store) else $error("v86 table base access wrong");
  property p_flags;
    @(posedge CLK_I) disable iff (!RSTN_I)
    (ACC_VALID_I && MODE_I == rafm_pkg::MODE_V86 && CLASS_I == rafm_pkg::RC_FLAGS)
    |=> (ACC_GRANT_O == ($past(CPL_I) <= $past(IO_PRIVILEGE_LEVEL_I)));
  endproperty
  a_flags: assert property (p_flags) else $error("flag access ignores io level");
  property p_general;
    @(posedge CLK_I) disable iff (!RSTN_I)
    (ACC_VALID_I && CLASS_I == rafm_pkg::RC_GENERAL && MODE_I != 2'h3) |=> ACC_GRANT_O;
  endproperty
  a_general: assert property (p_general) else $error("general register refused");
  property p_excl;
    @(posedge CLK_I) disable iff (!RSTN_I)
    ACC_DONE_O |-> (ACC_GRANT_O ^ PROT_FAULT_O);
  endproperty
  a_excl: assert property (p_excl) else $error("grant and fault not exclusive");
  property p_real_addr;
    @(posedge CLK_I) disable iff (!RSTN_I)
    (ADDR_VALID_I && MODE_I == rafm_pkg::MODE_REAL) |=>
    LINEAR_O == ({12'h000, $past(SELECTOR_I), 4'h0} + $past(BASE_I) + $past(INDEX_I)
                 + $past(DISP_I));
  endproperty
  a_real_addr: assert property (p_real_addr) else $error("real mode linear address wrong");
  property p_prot_addr;
    @(posedge CLK_I) disable iff (!RSTN_I)
    (ADDR_VALID_I && MODE_I == rafm_pkg::MODE_PROT) |=>
    LINEAR_O == ($past(SEG_BASE_I) + $past(BASE_I) + $past(INDEX_I) + $past(DISP_I));
  endproperty
  a_prot_addr: assert property (p_prot_addr) else $error("protected linear address wrong");
  property p_nopage;
    @(posedge CLK_I) disable iff (!RSTN_I)
    (ADDR_VALID_I && !PAGING_EN_I) |=> (PHYS_O == LINEAR_O) && !XLATE_REQ_O;
  endproperty
  a_nopage: assert property (p_nopage) else $error("physical differs with paging off");
  property p_lanes;
    @(posedge CLK_I) disable iff (!RSTN_I)
    (ADDR_VALID_I && SIZE_I == rafm_pkg::SIZE_DWORD) |=> MEM_LANES_O == 4'hf;
  endproperty
  a_lanes: assert property (p_lanes) else $error("doubleword lanes wrong");

  // Multi-step checks share the request and refusal sequences below.
  sequence s_v86_ctrl_load;
    ACC_VALID_I && MODE_I == rafm_pkg::MODE_V86 && CLASS_I == rafm_pkg::RC_CONTROL
    && !ACC_STORE_I;
  endsequence
  sequence s_refused;
    ACC_DONE_O && PROT_FAULT_O && !ACC_GRANT_O;
  endsequence
  sequence s_prot_sel_load;
    ACC_VALID_I && MODE_I == rafm_pkg::MODE_PROT && CPL_I != 2'h0 && !ACC_STORE_I
    && (CLASS_I == rafm_pkg::RC_LOCAL_SEL || CLASS_I == rafm_pkg::RC_TASK_SEL);
  endsequence
  property p_v86_ctrl;
    @(posedge CLK_I) disable iff (!RSTN_I)
    s_v86_ctrl_load |=> s_refused;
  endproperty
  a_v86_ctrl: assert property (p_v86_ctrl) else $error("v86 control load granted");
  property p_prot_sel;
    @(posedge CLK_I) disable iff (!RSTN_I)
    s_prot_sel_load |=> s_refused;
  endproperty
  a_prot_sel: assert property (p_prot_sel) else $error("selector load granted above 0");
  property p_bad_mode;
    @(posedge CLK_I) disable iff (!RSTN_I)
    (ACC_VALID_I && MODE_I == 2'h3) |=> s_refused;
  endproperty
  a_bad_mode: assert property (p_bad_mode) else $error("illegal mode access granted");
  property p_idle;
    @(posedge CLK_I) disable iff (!RSTN_I)
    !ACC_VALID_I |=> !ACC_DONE_O && !ACC_GRANT_O && !PROT_FAULT_O;
  endproperty
  a_idle: assert property (p_idle) else $error("access answer without request");
  property p_word_lanes;
    @(posedge CLK_I) disable iff (!RSTN_I)
    (ADDR_VALID_I && SIZE_I == rafm_pkg::SIZE_WORD) |=> MEM_LANES_O == 4'h3;
  endproperty
  a_word_lanes: assert property (p_word_lanes) else $error("word lanes wrong");
  property p_data;
    @(posedge CLK_I) disable iff (!RSTN_I)
    ADDR_VALID_I |=> MEM_DATA_O == $past(STORE_DATA_I);
  endproperty
  a_data: assert property (p_data) else $error("store data not passed in lane order");
  property p_paged;
    @(posedge CLK_I) disable iff (!RSTN_I)
    (ADDR_VALID_I && PAGING_EN_I) |=> XLATE_REQ_O && PHYS_O == 32'h0000_0000;
  endproperty
  a_paged: assert property (p_paged) else $error("paged address not sent to translation");
  property p_hold;
    @(posedge CLK_I) disable iff (!RSTN_I)
    !ADDR_VALID_I |=> $stable(LINEAR_O) && !ADDR_VALID_O;
  endproperty
  a_hold: assert property (p_hold) else $error("linear address moved while idle");
endmodule

// >>> tb/rafm_tb.sv
// Self-checking testbench for the register access check and address formation block.
`timescale 1ns/100ps
module tb;
  // ----------------------------------------------------------------------
  // Clock, reset, stimulus and observed signals
  // ----------------------------------------------------------------------
  logic        clk_i   = 1'b0;
  logic        rstn_i  = 1'b0;
  logic [1:0]  mode_i  = 2'h0;
  logic [3:0]  class_i = 4'h0;
  logic        acc_v_i = 1'b0;
  logic        store_i = 1'b0;
  logic [1:0]  cpl_i   = 2'h0;
  logic [1:0]  io_privilege_level_i  = 2'h0;
  logic        addr_vi = 1'b0;
  logic [15:0] sel_i   = 16'h0000;
  logic [31:0] sbase_i = 32'h0000_0000;
  logic [31:0] base_i  = 32'h0000_0000;
  logic [31:0] index_i = 32'h0000_0100;
  logic [31:0] disp_i  = 32'h0000_0020;
  logic        pg_i    = 1'b0;
  logic [31:0] data_i  = 32'h1122_3344;
  logic [1:0]  size_i  = 2'h0;
  logic        done_o, grant_o, fault_o, addr_vo, xlate_o;
  logic [31:0] lin_o, phys_o, mdata_o;
  logic [3:0]  lanes_o;
  int          errors   = 0;
  int          n_checks = 0;
  int          cycles   = 0;

  rafm_core dut (
    .CLK_I(clk_i), .RSTN_I(rstn_i), .MODE_I(mode_i), .CLASS_I(class_i),
    .ACC_VALID_I(acc_v_i), .ACC_STORE_I(store_i), .CPL_I(cpl_i), .IO_PRIVILEGE_LEVEL_I(io_privilege_level_i),
    .ADDR_VALID_I(addr_vi), .SELECTOR_I(sel_i), .SEG_BASE_I(sbase_i), .BASE_I(base_i),
    .INDEX_I(index_i), .DISP_I(disp_i), .PAGING_EN_I(pg_i), .STORE_DATA_I(data_i),
    .SIZE_I(size_i), .ACC_DONE_O(done_o), .ACC_GRANT_O(grant_o), .PROT_FAULT_O(fault_o),
    .ADDR_VALID_O(addr_vo), .LINEAR_O(lin_o), .PHYS_O(phys_o), .XLATE_REQ_O(xlate_o),
    .MEM_DATA_O(mdata_o), .MEM_LANES_O(lanes_o)
  );

  // A 20 ns period; the ceiling is far above the roughly 520 cycles the tests take.
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------------
  // Shared compare, expectation and closing tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Worked out independently from the permission table; encodings follow the package.
  function automatic logic f_allow(int m, int c, logic st, logic [1:0] pl, logic [1:0] io);
    logic z;
    z = (pl == 2'h0);
    if (m == 3 || c == 15) return 1'b0;
    if (c <= 1 || (c >= 8 && c <= 12)) return 1'b1;
    if (m == 0) return !(c == 6 || c == 7);
    if (c == 2) return (m == 1) ? 1'b1 : (pl <= io);
    if (m == 2) return st && (c >= 3 && c <= 5);
    if (c >= 4 && c <= 7) return st || z;
    return z;
  endfunction

  task automatic end_sim();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Every mode, class, direction and level back to back; the request stays raised.
  task automatic t_access();
    logic e;
    for (int m = 0; m < 4; m++)
      for (int c = 0; c < 16; c++)
        for (int s = 0; s < 2; s++)
          for (int p = 0; p < 4; p++) begin
            mode_i  = 2'(m);
            class_i = 4'(c);
            store_i = s[0];
            cpl_i   = 2'(p);
            io_privilege_level_i  = ~cpl_i;
            acc_v_i = 1'b1;
            e = f_allow(m, c, s[0], 2'(p), ~2'(p));
            @(negedge clk_i);
            chk(32'(done_o), 32'h0000_0001);
            chk(32'(grant_o), 32'(e));
            chk(32'(fault_o), 32'(!e));
          end
    acc_v_i = 1'b0;
    @(negedge clk_i);
    chk(32'({done_o, fault_o}), 32'h0000_0000);
    $display("test access done");
  endtask

  // Base, index and displacement add up to the offset, so each component matters.
  task automatic t_addr(input logic [1:0] m, input logic [15:0] sel, input logic [31:0] sb,
                        input logic [31:0] ofs, input logic pg, input logic [1:0] sz);
    logic [31:0] lin;
    logic [3:0]  ln;
    logic [31:0] msk;
    mode_i  = m;
    sel_i   = sel;
    sbase_i = sb;
    base_i  = ofs - 32'h0000_0120;
    pg_i    = pg;
    size_i  = sz;
    addr_vi = 1'b1;
    lin = (m == 2'h1) ? sb + ofs : ({16'h0000, sel} << 4) + ofs;
    ln  = (sz == 2'h0) ? 4'h1 : (sz == 2'h1) ? 4'h3 : 4'hf;
    msk = {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
    data_i = 32'h1122_3344 & msk;
    @(negedge clk_i);
    chk(32'(addr_vo), 32'h0000_0001);
    chk(lin_o, lin);
    chk(phys_o, pg ? 32'h0000_0000 : lin);
    chk(32'(xlate_o), 32'(pg));
    chk(32'(lanes_o), 32'(ln));
    chk(mdata_o, data_i);
  endtask

  task automatic t_address();
    t_addr(2'h0, 16'h1234, 32'h0000_0000, 32'h0000_0005, 1'b0, 2'h1);
    t_addr(2'h2, 16'hffff, 32'hdead_0000, 32'hffff_fff0, 1'b0, 2'h2);
    t_addr(2'h1, 16'h0008, 32'h0010_0000, 32'h0000_1234, 1'b0, 2'h0);
    t_addr(2'h1, 16'h0008, 32'h8000_0000, 32'h8000_0001, 1'b1, 2'h2);
    addr_vi = 1'b0;
    @(negedge clk_i);
    chk(32'(addr_vo), 32'h0000_0000);
    chk(lin_o, 32'h0000_0001);
    $display("test address done");
  endtask

  // Reset for three cycles, confirm quiet outputs, then run the scenarios.
  initial begin
    repeat (3) @(negedge clk_i);
    chk(32'({done_o, grant_o, fault_o, addr_vo, xlate_o}), 32'h0000_0000);
    rstn_i = 1'b1;
    @(negedge clk_i);
    t_access();
    t_address();
    end_sim();
  end
endmodule
